// [shared/fcso_pkg.sv]
package fcso_pkg;

  // ****************************************************************
  // Register map (printed offsets are indices, byte address = 4 x index)
  // ****************************************************************
  localparam int          APB_ADDR_W      = 18;
  localparam int          APB_DATA_W      = 32;
  localparam logic [15:0] CFG_INDEX       = 16'he706;
  localparam logic [15:0] STATUS_INDEX    = 16'he707;
  localparam logic [17:0] CFG_ADDR        = {CFG_INDEX, 2'b00};
  localparam logic [17:0] STATUS_ADDR     = {STATUS_INDEX, 2'b00};

  // ****************************************************************
  // Configuration register fields
  // ****************************************************************
  localparam int          CFG_W           = 8;
  localparam logic [7:0]  CFG_RESET       = 8'h00;
  localparam logic [7:0]  CFG_WRITE_MASK  = 8'h3f;
  localparam int          CFG_RATE_BIT    = 0;
  localparam int          CFG_SIZE_BIT    = 1;
  localparam int          CFG_GAP_BIT     = 2;
  localparam int          CFG_XFER_LSB    = 3;
  localparam int          CFG_POL_BIT     = 5;

  // ****************************************************************
  // Status register fields
  // ****************************************************************
  localparam int          STAT_BUSY_BIT   = 0;
  localparam int          STAT_FIFO_LSB   = 4;
  localparam int          STAT_SENT_LSB   = 8;

  // ****************************************************************
  // Transfer sets
  // ****************************************************************
  localparam logic [1:0]  XFER_FULL       = 2'b00;
  localparam logic [1:0]  XFER_WAVE       = 2'b01;
  localparam logic [1:0]  XFER_POWER      = 2'b10;
  localparam logic [4:0]  SET_FULL_LEN    = 5'h10;
  localparam logic [4:0]  SET_WAVE_LEN    = 5'h07;
  localparam logic [4:0]  SET_POWER_LEN   = 5'h09;
  localparam logic [3:0]  POWER_BASE      = 4'h7;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int          PCLK_PERIOD_NS  = 4;
  localparam int          SCLK_FAST_NS    = 125;
  localparam int          SCLK_SLOW_NS    = 250;
  localparam int          HALF_FAST_CYC   =
    (SCLK_FAST_NS + 2 * PCLK_PERIOD_NS - 1) / (2 * PCLK_PERIOD_NS);
  localparam int          HALF_SLOW_CYC   =
    (SCLK_SLOW_NS + 2 * PCLK_PERIOD_NS - 1) / (2 * PCLK_PERIOD_NS);
  localparam logic [5:0]  WORD_BITS       = 6'h20;
  localparam int          GAP_PERIODS     = 7;
  localparam logic [4:0]  GAP_HALVES      = 5'(2 * GAP_PERIODS);

  typedef enum logic [2:0] {
    FCSO_IDLE, FCSO_WAIT, FCSO_LOW, FCSO_HIGH, FCSO_GAP
  } fcso_state_t;

  // Quantity code presented on the fetch port for a position in the set
  function automatic logic [3:0] fcso_word_code(input logic [1:0] xfer,
                                                input logic [3:0] pos);
    fcso_word_code = (xfer == XFER_POWER) ? 4'(pos + POWER_BASE) : pos;
  endfunction

  function automatic logic [4:0] fcso_set_len(input logic [1:0] xfer);
    case (xfer)
      XFER_WAVE:  fcso_set_len = SET_WAVE_LEN;
      XFER_POWER: fcso_set_len = SET_POWER_LEN;
      default:    fcso_set_len = SET_FULL_LEN;
    endcase
  endfunction

endpackage

// [hdl/fcso_capture_port.sv]
`timescale 1ns/100ps

// ******************************************************************
// Word FIFO between the value fetcher and the serialiser
// ******************************************************************
module fcso_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 4
) (
  input  wire logic                       pclk,
  input  wire logic                       presetn,
  input  wire logic                       ce,
  input  wire logic                       in_valid,
  output logic                            in_ready,
  input  wire logic [WIDTH-1:0]           in_data,
  output logic                            out_valid,
  input  wire logic                       out_ready,
  output logic [WIDTH-1:0]                out_data,
  output logic [$clog2(DEPTH+1)-1:0]      level
);
  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PW-1:0]    wr_ptr_q;
  logic [PW-1:0]    rd_ptr_q;
  logic [CW-1:0]    count_q;
  logic             push;
  logic             pop;

  // Full and empty come from the count, so all DEPTH entries are usable.
  assign in_ready  = (count_q != CW'(DEPTH));
  assign out_valid = (count_q != '0);
  assign out_data  = mem_q[rd_ptr_q];
  assign level     = count_q;
  assign push      = ce && in_valid && in_ready;
  assign pop       = ce && out_valid && out_ready;

  function automatic logic [PW-1:0] next_ptr(input logic [PW-1:0] p);
    next_ptr = (p == PW'(DEPTH - 1)) ? '0 : PW'(p + 1'b1);
  endfunction

  always_ff @(posedge pclk) begin
    if (push) begin
      mem_q[wr_ptr_q] <= in_data;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q  <= '0;
    end else begin
      if (push) begin
        wr_ptr_q <= next_ptr(wr_ptr_q);
      end
      if (pop) begin
        rd_ptr_q <= next_ptr(rd_ptr_q);
      end
      if (push && !pop) begin
        count_q <= CW'(count_q + 1'b1);
      end else if (pop && !push) begin
        count_q <= CW'(count_q - 1'b1);
      end
    end
  end
endmodule

// Operation
// R1 - Serial clock 8 MHz, 4 MHz when selected
// R2 - 32-bit or byte packages, MSB first
// R3 - Optional seven-period idle gap between packages
// R4 - Set 00: sixteen words, waves then powers
// R5 - Set 01: seven waveform words only
// R6 - Set 10: nine phase-power words only
// R7 - Reserved set 11 behaves as 00
// R8 - Strobe polarity: low when 0, high when 1
// R9 - Host samples data on rising serial clock
// R10 - Reserved config bits ignored, no effect
module fcso_capture_port
  import fcso_pkg::*;
#(
  parameter int FIFO_DEPTH = 4
) (
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic                  ce,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [APB_ADDR_W-1:0] paddr,
  input  wire logic [APB_DATA_W-1:0] pwdata,
  output logic      [APB_DATA_W-1:0] prdata,
  output logic                       pready,
  output logic                       pslverr,
  input  wire logic                  frame_start,
  output logic      [3:0]            value_sel,
  input  wire logic                  value_valid,
  input  wire logic [31:0]           value_data,
  output logic                       value_ready,
  output logic                       capture_serial_clock,
  output logic                       capture_serial_data,
  output logic                       select_active_strobe
);
  localparam int LW = $clog2(FIFO_DEPTH + 1);

  fcso_state_t           state_q;
  logic [CFG_W-1:0]      cfg_q;
  logic [CFG_W-1:0]      snap_q;
  logic                  frame_q;
  logic [3:0]            fetch_pos_q;
  logic                  fetch_busy_q;
  logic [4:0]            sent_q;
  logic [31:0]           shift_q;
  logic [5:0]            bits_q;
  logic [4:0]            gap_q;
  logic [5:0]            half_q;
  logic                  sclk_q;
  logic                  strobe_q;
  logic [APB_DATA_W-1:0] prdata_q;
  logic                  word_tick;
  logic                  fifo_in_ready;
  logic                  fifo_out_valid;
  logic                  fifo_pop;
  logic [31:0]           fifo_out_data;
  logic [LW-1:0]         fifo_level;
  logic                  half_done;
  logic [5:0]            half_len;
  logic                  pkg_end;
  logic                  word_end;
  logic                  set_end;
  logic                  start_ok;
  logic                  apb_setup;
  logic                  apb_write;
  logic                  addr_hit;

  // ****************************************************************
  // APB slave
  // ****************************************************************
  // Reads are captured in the setup phase so prdata comes from a flop;
  // a frozen clock enable simply stretches the access phase.
  // Limitation: a setup cycle seen with ce low is lost, so software must
  // not start a read while the enable is held low.
  assign pready    = ce;
  assign apb_setup = ce && psel && !penable;
  assign apb_write = ce && psel && penable && pwrite;
  assign addr_hit  = (paddr == CFG_ADDR) || (paddr == STATUS_ADDR);
  assign pslverr   = psel && penable && !addr_hit;
  assign prdata    = prdata_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_q <= CFG_RESET;
    end else if (apb_write && paddr == CFG_ADDR) begin
      cfg_q <= pwdata[CFG_W-1:0] & CFG_WRITE_MASK;  // [R10]
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= '0;
    end else if (apb_setup && !pwrite) begin
      prdata_q <= '0;
      if (paddr == CFG_ADDR) begin
        prdata_q[CFG_W-1:0] <= cfg_q;
      end else if (paddr == STATUS_ADDR) begin
        prdata_q[STAT_BUSY_BIT]                 <= frame_q;
        prdata_q[STAT_FIFO_LSB +: LW]           <= fifo_level;
        prdata_q[STAT_SENT_LSB +: 5]            <= sent_q;
      end
    end
  end

  // ****************************************************************
  // Value fetcher: walks the selected set into the FIFO
  // ****************************************************************
  // The config is snapshotted at frame start so a write mid-frame
  // cannot change the word count the host is expecting.
  assign start_ok    = ce && frame_start && !frame_q;
  assign value_sel   = fcso_word_code(snap_q[CFG_XFER_LSB +: 2],
                                      fetch_pos_q);  // [R4] [R5] [R6]
  assign value_ready = fetch_busy_q && fifo_in_ready;
  assign word_tick   = ce && value_valid && value_ready;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fetch_pos_q  <= '0;
      fetch_busy_q <= 1'b0;
      snap_q       <= CFG_RESET;
    end else if (start_ok) begin
      fetch_pos_q  <= '0;
      fetch_busy_q <= 1'b1;
      snap_q       <= cfg_q;
    end else if (word_tick) begin
      fetch_pos_q <= 4'(fetch_pos_q + 1'b1);
      // Reserved code falls to the full sixteen-word set. Widen before
      // the add so that the last of sixteen positions reaches the length.
      if (({1'b0, fetch_pos_q} + 5'h01) ==
          fcso_set_len(snap_q[CFG_XFER_LSB +: 2])) begin  // [R7]
        fetch_busy_q <= 1'b0;
      end
    end
  end

  fcso_fifo #(
    .WIDTH (32),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .pclk      (pclk),
    .presetn   (presetn),
    .ce        (ce),
    .in_valid  (value_valid && fetch_busy_q),
    .in_ready  (fifo_in_ready),
    .in_data   (value_data),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_pop),
    .out_data  (fifo_out_data),
    .level     (fifo_level)
  );

  // ****************************************************************
  // Serialiser
  // ****************************************************************
  // Clock idles low; data changes with the falling edge and the host
  // samples on the rising one. [R9]
  // Half-period is rounded up, so the clock never runs above rate.
  // Byte packages reuse the word counter: one ends at bits 25, 17, 9, 1.
  assign half_len  = snap_q[CFG_RATE_BIT] ? 6'(HALF_SLOW_CYC - 1)
                                          : 6'(HALF_FAST_CYC - 1);  // [R1]
  assign half_done = (half_q == '0);
  assign word_end  = (bits_q == 6'h01);
  assign pkg_end   = word_end ||
                     (snap_q[CFG_SIZE_BIT] && bits_q[2:0] == 3'b001);  // [R2]
  assign set_end   = word_end &&
                     (5'(sent_q + 1'b1) ==
                      fcso_set_len(snap_q[CFG_XFER_LSB +: 2]));
  assign fifo_pop  = ce && state_q == FCSO_WAIT && fifo_out_valid;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= FCSO_IDLE;
      frame_q <= 1'b0;
      sent_q  <= '0;
      shift_q <= '0;
      bits_q  <= '0;
      gap_q   <= '0;
      half_q  <= '0;
      sclk_q  <= 1'b0;
    end else if (ce) begin
      case (state_q)
        FCSO_IDLE: begin
          sclk_q <= 1'b0;
          if (start_ok) begin
            frame_q <= 1'b1;
            sent_q  <= '0;
            state_q <= FCSO_WAIT;
          end
        end
        FCSO_WAIT: begin
          // An empty FIFO holds the clock low with the strobe active.
          // Limitation: this pop cycle stretches the low half at every
          // word boundary by one clock.
          if (fifo_out_valid) begin
            shift_q <= fifo_out_data;  // [R2]
            bits_q  <= WORD_BITS;
            half_q  <= half_len;
            state_q <= FCSO_LOW;
          end
        end
        FCSO_LOW: begin
          if (half_done) begin
            sclk_q  <= 1'b1;
            half_q  <= half_len;
            state_q <= FCSO_HIGH;
          end else begin
            half_q <= 6'(half_q - 1'b1);
          end
        end
        FCSO_HIGH: begin
          if (!half_done) begin
            half_q <= 6'(half_q - 1'b1);
          end else begin
            sclk_q  <= 1'b0;
            half_q  <= half_len;
            bits_q  <= 6'(bits_q - 1'b1);
            shift_q <= {shift_q[30:0], 1'b0};  // [R2]
            if (word_end) begin
              sent_q <= 5'(sent_q + 1'b1);
            end
            if (set_end) begin
              frame_q <= 1'b0;
              state_q <= FCSO_IDLE;
            end else if (pkg_end && snap_q[CFG_GAP_BIT]) begin
              gap_q   <= GAP_HALVES;  // [R3]
              state_q <= FCSO_GAP;
            end else if (word_end) begin
              state_q <= FCSO_WAIT;  // [R3]
            end else begin
              state_q <= FCSO_LOW;
            end
          end
        end
        FCSO_GAP: begin
          // Seven whole serial periods with the clock parked low
          if (!half_done) begin
            half_q <= 6'(half_q - 1'b1);
          end else if (gap_q != 5'h01) begin
            gap_q  <= 5'(gap_q - 1'b1);
            half_q <= half_len;
          end else if (bits_q == '0) begin
            state_q <= FCSO_WAIT;  // [R3]
          end else begin
            half_q  <= half_len;
            state_q <= FCSO_LOW;  // [R3]
          end
        end
        default: begin
          state_q <= FCSO_IDLE;
          frame_q <= 1'b0;
        end
      endcase
    end
  end

  // ****************************************************************
  // Pin drivers
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strobe_q <= 1'b1;
    end else if (ce) begin
      // Polarity follows the live register so the idle level is right
      // even before the first frame.
      strobe_q <= cfg_q[CFG_POL_BIT] ? frame_q : !frame_q;  // [R8]
    end
  end

  assign capture_serial_clock = sclk_q;
  assign capture_serial_data  = shift_q[31];
  assign select_active_strobe = strobe_q;

endmodule

// [test/fcso_capture_port_assertions.sv]
`timescale 1ns/100ps
module fcso_chk
  import fcso_pkg::*;
#(
  parameter int FIFO_DEPTH = 4
) (
  input wire logic                  pclk,
  input wire logic                  presetn,
  input wire logic                  ce,
  input wire logic                  psel,
  input wire logic                  penable,
  input wire logic                  pwrite,
  input wire logic [APB_ADDR_W-1:0] paddr,
  input wire logic [APB_DATA_W-1:0] pwdata,
  input wire logic [APB_DATA_W-1:0] prdata,
  input wire logic                  pready,
  input wire logic                  pslverr,
  input wire logic                  frame_start,
  input wire logic [3:0]            value_sel,
  input wire logic                  value_valid,
  input wire logic [31:0]           value_data,
  input wire logic                  value_ready,
  input wire logic                  capture_serial_clock,
  input wire logic                  capture_serial_data,
  input wire logic                  select_active_strobe
);
  logic [7:0] cfg_q;
  int         hi_cnt_q;
  logic       act;

  // Shadow of the config register, seen from the bus side only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_q <= 8'h00;
    end else if (psel && penable && pwrite && ce && paddr == CFG_ADDR) begin
      cfg_q <= pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hi_cnt_q <= 0;
    end else begin
      hi_cnt_q <= capture_serial_clock ? hi_cnt_q + 1 : 0;
    end
  end

  assign act = select_active_strobe == cfg_q[CFG_POL_BIT];

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_start;
    frame_start && !act && !capture_serial_clock;
  endsequence

  a_pready_is_ce: assert property (pready == ce)
    else $error("pready differs from ce");
  a_unmapped_err: assert property (psel && penable && paddr != CFG_ADDR
    && paddr != STATUS_ADDR |-> pslverr)
    else $error("no error on unmapped access");
  a_cfg_rsvd_zero: assert property (
    psel && penable && !pwrite && paddr == CFG_ADDR |-> prdata[7:6] == 2'b00)
    else $error("reserved config bits read nonzero");
  a_sclk_half_len: assert property ($fell(capture_serial_clock) |->
    hi_cnt_q == (cfg_q[CFG_RATE_BIT] ? HALF_SLOW_CYC : HALF_FAST_CYC))
    else $error("serial clock high half wrong length");
  a_strobe_on_clk: assert property ($rose(capture_serial_clock) |-> act)
    else $error("serial clock edge outside active strobe");
  a_idle_clk_low: assert property (!act |-> !capture_serial_clock)
    else $error("serial clock high while strobe inactive");
  a_data_hold_high: assert property (
    capture_serial_clock |-> $stable(capture_serial_data))
    else $error("data changed while serial clock high");
  a_start_strobe: assert property (s_start |-> ##[1:3] act)
    else $error("strobe late after frame start");
  a_sel_hold: assert property (
    value_ready && !value_valid |=> $stable(value_sel))
    else $error("value select moved without handshake");
endmodule

// [test/fcso_host_model.sv]
`timescale 1ns/100ps
module fcso_host_model (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        clr,
  input  wire logic        sclk,
  input  wire logic        sdata,
  input  wire logic        strobe,
  input  wire logic        pol,
  output logic      [31:0] words [16],
  output int               n_words,
  output int               n_gaps,
  output int               max_low
);
  logic [31:0] sh_q;
  int          nbits_q;
  int          lo_q;
  logic        sclk_q;

  // Host only listens; the serial clock is sampled, not used as a clock
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {n_words, n_gaps, max_low, nbits_q, lo_q} <= '0;
      sclk_q <= 1'b0;
      sh_q <= 32'h0000_0000;
    end else if (clr) begin
      {n_words, n_gaps, max_low, nbits_q, lo_q} <= '0;
    end else begin
      sclk_q <= sclk;
      lo_q <= (strobe == pol && !sclk) ? lo_q + 1 : 0;
      if (sclk && !sclk_q && strobe == pol && nbits_q < 512) begin
        sh_q <= {sh_q[30:0], sdata};
        nbits_q <= nbits_q + 1;
        if (nbits_q % 32 == 31) begin
          words[4'(nbits_q / 32)] <= {sh_q[30:0], sdata};
          n_words <= nbits_q / 32 + 1;
        end
        // Long low runs between packages are gaps
        if (nbits_q > 0 && lo_q > 100) n_gaps <= n_gaps + 1;
        // Bit clock low half inside a word; word boundaries also pop
        if (nbits_q % 32 != 0 && lo_q > max_low) max_low <= lo_q;
      end
    end
  end
endmodule

// [test/tb.sv]
`timescale 1ns/100ps
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin error_cnt++; \
  $display("[ERR] %0t got %h exp %h", $time, (a), (e)); end end
module tb
  import fcso_pkg::*;
;
  logic        pclk = 0, presetn = 0, ce = 1, clr = 0;
  logic        psel = 0, penable = 0, pwrite = 0, pready, pslverr;
  logic [17:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, value_data = '0;
  logic [3:0]  value_sel, sel_q = '0;
  logic        frame_start = 0, value_valid = 0, value_ready;
  logic        capture_serial_clock, capture_serial_data;
  logic        select_active_strobe;
  logic [31:0] words [16];
  int          n_words, n_gaps, max_low, error_cnt = 0, n_checks = 0;

  always #2 pclk = ~pclk;

  function automatic logic [31:0] pat(input logic [3:0] s);
    return {s, 24'h5a_c3e1, ~s};
  endfunction

  logic        pol_q = 0;

  // Offer data only once the select has settled for a cycle; a frame
  // start moves the select, so a word made for the old one is withdrawn
  always @(posedge pclk) begin
    sel_q <= value_sel;
    value_data <= pat(value_sel);
    value_valid <= (value_sel === sel_q) && !frame_start &&
                   !(value_valid && value_ready);
  end

  fcso_capture_port #(.FIFO_DEPTH(4)) dut_u (
    .pclk                 (pclk),
    .presetn              (presetn),
    .ce                   (ce),
    .psel                 (psel),
    .penable              (penable),
    .pwrite               (pwrite),
    .paddr                (paddr),
    .pwdata               (pwdata),
    .prdata               (prdata),
    .pready               (pready),
    .pslverr              (pslverr),
    .frame_start          (frame_start),
    .value_sel            (value_sel),
    .value_valid          (value_valid),
    .value_data           (value_data),
    .value_ready          (value_ready),
    .capture_serial_clock (capture_serial_clock),
    .capture_serial_data  (capture_serial_data),
    .select_active_strobe (select_active_strobe)
  );
  fcso_host_model host_u (.pclk(pclk), .presetn(presetn), .clr(clr),
    .sclk(capture_serial_clock), .sdata(capture_serial_data),
    .strobe(select_active_strobe), .pol(pol_q), .words(words),
    .n_words(n_words), .n_gaps(n_gaps), .max_low(max_low));

  task test_done;
    if (error_cnt == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task timeout;
    error_cnt++;
    $display("[ERR] %0t timeout", $time);
    test_done();
  endtask

  task apb(input logic wr, input logic [17:0] a, input logic [31:0] d,
           output logic [31:0] rd, output logic err);
    int i;
    @(posedge pclk);
    psel <= 1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    for (i = 0; i < 50; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (i == 50) timeout();
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask

  task scn_regs;
    logic [31:0] rd;
    logic        err;
    apb(0, CFG_ADDR, 0, rd, err);
    `CHK(rd, {24'h00_0000, CFG_RESET})
    apb(1, CFG_ADDR, 32'h0000_00ff, rd, err);
    apb(0, CFG_ADDR, 0, rd, err);
    `CHK(rd, 32'h0000_003f)
    apb(0, 18'h0_0010, 0, rd, err);
    `CHK({err, rd}, {1'b1, 32'h0000_0000})
  endtask

  task run_frame(input logic [7:0] cfg, input int first, input int n,
                 input int gaps);
    logic [31:0] rd;
    logic        err;
    int          i;
    apb(1, CFG_ADDR, {24'h00_0000, cfg}, rd, err);
    pol_q <= cfg[5];
    @(posedge pclk);
    clr <= 1;
    frame_start <= 1;
    @(posedge pclk);
    clr <= 0;
    frame_start <= 0;
    for (i = 0; i < 200; i++) begin
      @(posedge pclk);
      if (select_active_strobe === cfg[5]) break;
    end
    if (i == 200) timeout();
    for (i = 0; i < 40000; i++) begin
      @(posedge pclk);
      if (select_active_strobe === !cfg[5]) break;
    end
    if (i == 40000) timeout();
    repeat (2) @(posedge pclk);
    `CHK(n_words, n)
    `CHK(n_gaps, gaps)
    for (i = 0; i < n; i++) `CHK(words[i], pat(4'(first + i)))
    apb(0, STATUS_ADDR, 0, rd, err);
    `CHK(rd, 32'(n) << STAT_SENT_LSB)
  endtask

  task scn_full;
    run_frame(8'h00, 0, 16, 0);
    `CHK(max_low, HALF_FAST_CYC)
  endtask

  task scn_wave_slow_gap;
    run_frame(8'h0d, 0, 7, 6);
    `CHK(max_low, HALF_SLOW_CYC)
  endtask

  task scn_power_bytes;
    run_frame(8'h16, 7, 9, 35);
  endtask

  task scn_rsvd_set_pol;
    run_frame(8'hf8, 0, 16, 0);
  endtask

  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1;
    scn_regs();
    scn_full();
    scn_wave_slow_gap();
    scn_power_bytes();
    scn_rsvd_set_pol();
    test_done();
  end
endmodule

bind fcso_capture_port fcso_chk #(.FIFO_DEPTH(FIFO_DEPTH)) chk_u (
  .pclk                 (pclk),
  .presetn              (presetn),
  .ce                   (ce),
  .psel                 (psel),
  .penable              (penable),
  .pwrite               (pwrite),
  .paddr                (paddr),
  .pwdata               (pwdata),
  .prdata               (prdata),
  .pready               (pready),
  .pslverr              (pslverr),
  .frame_start          (frame_start),
  .value_sel            (value_sel),
  .value_valid          (value_valid),
  .value_data           (value_data),
  .value_ready          (value_ready),
  .capture_serial_clock (capture_serial_clock),
  .capture_serial_data  (capture_serial_data),
  .select_active_strobe (select_active_strobe)
);
